// ==== verilog/tape_transport_diag_sequencer.sv ====
// Implementation choices: the address map and the plain strobed port.
`include "tape_diag_map.svh"

module tape_transport_diag_sequencer
  import tape_diag_pkg::*;
#(
  parameter int WIN_CYC      = `SPEED_WIN_US * `CLK_FREQ_MHZ,
  parameter int DBL_CYC      = `DBL_PRESS_MS * 1000 * `CLK_FREQ_MHZ,
  parameter int BUZZ_ON_CYC  = `BUZZ_ON_MS * 1000 * `CLK_FREQ_MHZ,
  parameter int BUZZ_OFF_CYC = `BUZZ_OFF_MS * 1000 * `CLK_FREQ_MHZ,
  parameter int MOVE_TICKS   = `MOVE_INCHES * `TICKS_PER_INCH,
  parameter int SETTLE_TICKS = `SETTLE_INCHES * `TICKS_PER_INCH,
  parameter int MID_TICKS    = `MID_TAPE_INCHES * `TICKS_PER_INCH
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic        START_BTN,
  input  wire logic [11:0] ADDR_SW,
  input  wire logic        DISPLAY_MAIN_SEL,
  input  wire logic        LEADER_BOT,
  input  wire logic        LEADER_EOT,
  input  wire logic        NEAR_END_OF_TAPE_HOLE,
  input  wire logic        SERVO_UNSAFE,
  input  wire logic        TAPE_TICK,
  input  wire logic        READ_FLUX,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  output logic             MOTOR_FWD,
  output logic             MOTOR_REV,
  output logic             MOTOR_FAST,
  output logic             HALT_LAMP,
  output logic             FAULT_LAMP,
  output logic      [11:0] INDICATOR,
  output logic             BUZZER,
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // Pin synchronisers and buzzer
  // ----------------------------------------------------------------
  sensors_t    sens;
  diag_state_t s_r;
  diag_state_t s_nxt;

  pin_sync #(
    .W ($bits(sensors_t))
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .ce    (CE),
    .pin   ({START_BTN, LEADER_BOT, LEADER_EOT, NEAR_END_OF_TAPE_HOLE, SERVO_UNSAFE,
             TAPE_TICK, READ_FLUX, DISPLAY_MAIN_SEL, ADDR_SW}),
    .q     (sens)
  );

  buzz_pulser #(
    .ON_CYC  (BUZZ_ON_CYC),
    .OFF_CYC (BUZZ_OFF_CYC)
  ) u_buzz (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .ce    (CE),
    .go    (s_r.buzz_go),
    .count (s_r.buzz_n),
    .buzz  (BUZZER)
  );

  // ----------------------------------------------------------------
  // Sequence helpers
  // ----------------------------------------------------------------
  function automatic diag_state_t halt_at(diag_state_t x, state_t st, logic [11:0] code,
                                          logic fault);
    x.st         = st;
    x.code       = code;
    x.halt_lamp  = 1'b1;
    x.fault_lamp = fault;
    return x;
  endfunction

  function automatic diag_state_t start_meas(diag_state_t x, logic fwd);
    x.st         = S_MEAS;
    x.meas_fwd   = fwd;
    x.ticks      = 16'h0000;
    x.win_on     = 1'b0;
    x.win_done   = 1'b0;
    x.halt_lamp  = 1'b0;
    x.fault_lamp = 1'b0;
    x.code       = fwd ? `ADDR_MEAS_FWD : `ADDR_MEAS_REV;
    return x;
  endfunction

  // Unknown routines park in idle and just echo the switches
  function automatic diag_state_t latch_routine(diag_state_t x, logic [11:0] addr);
    x.routine    = addr;
    x.code       = addr;
    x.halt_lamp  = 1'b0;
    x.fault_lamp = 1'b0;
    x.hole_seen  = 1'b0;
    case (addr)
      `ADDR_FWD_FAST: begin
        x.st      = S_PREPOS;
        x.dir_fwd = 1'b1;
      end
      `ADDR_REV_FAST: begin
        x.st      = S_PREPOS;
        x.dir_fwd = 1'b0;
      end
      `ADDR_SPEED: begin
        x.st      = S_PREPOS;
        x.dir_fwd = 1'b1;
        x.fwd_ok  = 1'b0;
      end
      default: begin
        x.st = S_IDLE;
      end
    endcase
    return x;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       press;
    logic       tick_e;
    logic       hole_e;
    logic       flux_e;
    logic       moving;
    logic       at_lead;
    logic       in_tol;
    logic       go_rev;
    logic [3:0] ev;
    logic [3:0] clr;
    press   = 1'b0;
    tick_e  = 1'b0;
    hole_e  = 1'b0;
    flux_e  = 1'b0;
    moving  = 1'b0;
    at_lead = 1'b0;
    in_tol  = 1'b0;
    go_rev  = 1'b0;
    ev      = 4'h0;
    clr     = 4'h0;
    s_nxt   = s_r;

    // A start counts on release of the button
    press   = s_r.start_q & ~sens.start;
    tick_e  = sens.tick & ~s_r.tick_q;
    hole_e  = sens.hole & ~s_r.hole_q;
    flux_e  = sens.flux & ~s_r.flux_q;
    moving  = s_r.motor_fwd | s_r.motor_rev;
    in_tol  = (s_r.speed >= `SPEED_TOL_LO) && (s_r.speed <= `SPEED_TOL_HI);

    s_nxt.start_q = sens.start;
    s_nxt.tick_q  = sens.tick;
    s_nxt.hole_q  = sens.hole;
    s_nxt.flux_q  = sens.flux;
    s_nxt.buzz_go = 1'b0;
    s_nxt.rd_data = 32'h0000_0000;

    case (s_r.st)
      S_IDLE, S_HALT, S_FAULT: begin
        // Halt display stands until the next start; lamps until a start or a CTRL abort write
        if (press) begin
          s_nxt = latch_routine(s_nxt, sens.addr);
        end
      end
      S_PREPOS: begin
        at_lead = s_r.dir_fwd ? sens.bot : sens.eot;
        if (at_lead) begin
          s_nxt.ticks     = 16'h0000;
          s_nxt.hole_seen = 1'b0;
          s_nxt.st        = (s_r.routine == `ADDR_SPEED) ? S_MIDSEEK : S_RUN;
        end
      end
      S_RUN: begin
        at_lead = s_r.dir_fwd ? sens.eot : sens.bot;
        if (hole_e) begin
          s_nxt.hole_seen = 1'b1;
        end
        if (at_lead) begin
          if (s_r.hole_seen || hole_e) begin
            s_nxt = halt_at(s_nxt, S_HALT, `CODE_RUN_END, 1'b0);
            ev[`IRQ_DONE] = 1'b1;
          end else begin
            s_nxt = halt_at(s_nxt, S_FAULT, `CODE_NO_HOLE, 1'b1);
            ev[`IRQ_FAULT] = 1'b1;
          end
        end
      end
      S_MIDSEEK: begin
        if (tick_e) begin
          s_nxt.ticks = s_r.ticks + 16'h0001;
        end
        if (s_r.ticks >= 16'(MID_TICKS)) begin
          s_nxt = halt_at(s_nxt, S_MIDHALT, `ADDR_MEAS_FWD, 1'b0);
          ev[`IRQ_DONE] = 1'b1;
        end
      end
      S_MIDHALT: begin
        if (press) begin
          s_nxt = start_meas(s_nxt, 1'b1);
        end
      end
      S_MEAS: begin
        if (tick_e) begin
          s_nxt.ticks = s_r.ticks + 16'h0001;
        end
        // Gate opens after settling so spin-up does not bias the code
        if (!s_r.win_on && !s_r.win_done && s_r.ticks >= 16'(SETTLE_TICKS)) begin
          s_nxt.win_on   = 1'b1;
          s_nxt.timer    = 26'(WIN_CYC - 1);
          s_nxt.flux_cnt = 8'h00;
        end else if (s_r.win_on) begin
          if (flux_e && s_r.flux_cnt != `SPEED_SAT) begin
            s_nxt.flux_cnt = s_r.flux_cnt + 8'h01;
          end
          if (s_r.timer == 26'h0) begin
            s_nxt.win_on   = 1'b0;
            s_nxt.win_done = 1'b1;
            s_nxt.speed    = s_nxt.flux_cnt;
          end else begin
            s_nxt.timer = s_r.timer - 26'h1;
          end
        end
        // Keeps moving past eight inches if the gate is still open
        if (s_r.win_done && s_r.ticks >= 16'(MOVE_TICKS)) begin
          s_nxt.buzz_go = 1'b1;
          if (s_r.speed < `SPEED_TOL_LO) begin
            s_nxt.buzz_n = `BUZZ_SLOW;
          end else if (s_r.speed > `SPEED_TOL_HI) begin
            s_nxt.buzz_n = `BUZZ_FAST;
          end else begin
            s_nxt.buzz_n = `BUZZ_TOL;
          end
          ev[`IRQ_MEAS] = 1'b1;
          ev[`IRQ_TOL]  = in_tol;
          if (s_r.meas_fwd) begin
            s_nxt.fwd_ok = in_tol;
          end
          if (in_tol) begin
            s_nxt = halt_at(s_nxt, S_MEASHALT, `ADDR_MEAS_END, 1'b0);
          end else begin
            s_nxt.st    = S_CORR;
            s_nxt.ticks = 16'h0000;
          end
        end
      end
      S_CORR: begin
        if (tick_e) begin
          s_nxt.ticks = s_r.ticks + 16'h0001;
        end
        if (s_r.ticks >= 16'(MOVE_TICKS)) begin
          s_nxt = halt_at(s_nxt, S_MEASHALT, `ADDR_MEAS_END, 1'b0);
        end
      end
      S_MEASHALT: begin
        if (press) begin
          s_nxt.st    = S_PRESS2;
          s_nxt.timer = 26'(DBL_CYC - 1);
        end
      end
      S_PRESS2: begin
        // Reverse is held back until forward has passed, when strict
        go_rev = s_r.meas_fwd && (s_r.fwd_ok || !s_r.ctrl[`CTRL_STRICT]);
        if (press) begin
          s_nxt = start_meas(s_nxt, !go_rev);
        end else if (s_r.timer == 26'h0) begin
          s_nxt = start_meas(s_nxt, s_r.meas_fwd);
        end else begin
          s_nxt.timer = s_r.timer - 26'h1;
        end
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase

    // Servo unsafe beats any sequence step while the tape moves
    if (moving && sens.servo) begin
      s_nxt = halt_at(s_nxt, S_FAULT, `CODE_SERVO, 1'b1);
      s_nxt.win_on   = 1'b0;
      ev[`IRQ_FAULT] = 1'b1;
      ev[`IRQ_DONE]  = 1'b0;
    end

    // Register writes
    if (REG_WR) begin
      case (REG_ADDR)
        `REG_INT_STAT: clr = REG_WDATA[3:0];
        `REG_INT_MASK: s_nxt.int_mask = REG_WDATA[3:0];
        `REG_CTRL: begin
          s_nxt.ctrl[`CTRL_STRICT] = REG_WDATA[`CTRL_STRICT];
          if (REG_WDATA[`CTRL_ABORT]) begin
            s_nxt.st         = S_IDLE;
            s_nxt.halt_lamp  = 1'b0;
            s_nxt.fault_lamp = 1'b0;
            s_nxt.win_on     = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Motor drive follows the state being entered
    s_nxt.motor_fwd  = 1'b0;
    s_nxt.motor_rev  = 1'b0;
    s_nxt.motor_fast = 1'b0;
    case (s_nxt.st)
      S_PREPOS: begin
        s_nxt.motor_fwd  = !s_nxt.dir_fwd;
        s_nxt.motor_rev  = s_nxt.dir_fwd;
        s_nxt.motor_fast = 1'b1;
      end
      S_RUN: begin
        s_nxt.motor_fwd  = s_nxt.dir_fwd;
        s_nxt.motor_rev  = !s_nxt.dir_fwd;
        s_nxt.motor_fast = 1'b1;
      end
      S_MIDSEEK: begin
        s_nxt.motor_fwd  = 1'b1;
        s_nxt.motor_fast = 1'b1;
      end
      S_MEAS: begin
        s_nxt.motor_fwd = s_nxt.meas_fwd;
        s_nxt.motor_rev = !s_nxt.meas_fwd;
      end
      S_CORR: begin
        s_nxt.motor_fwd = !s_nxt.meas_fwd;
        s_nxt.motor_rev = s_nxt.meas_fwd;
      end
      default: begin
      end
    endcase

    // Main register view shows the speed code with the top nibble dark
    s_nxt.ind = sens.main_view ? {4'h0, s_nxt.speed} : s_nxt.code;

    // A set in the same cycle as its clear is kept
    s_nxt.int_stat = (s_r.int_stat & ~clr) | ev;
    s_nxt.irq      = |(s_nxt.int_stat & s_nxt.int_mask);

    if (REG_RD) begin
      case (REG_ADDR)
        `REG_STATUS: s_nxt.rd_data = {10'h000, s_r.fwd_ok, s_r.fault_lamp, s_r.halt_lamp,
                                      s_r.motor_fast, s_r.motor_rev, s_r.motor_fwd,
                                      s_r.st, s_r.routine};
        `REG_INT_STAT: s_nxt.rd_data = {28'h0000000, s_r.int_stat};
        `REG_INT_MASK: s_nxt.rd_data = {28'h0000000, s_r.int_mask};
        `REG_SPEED: s_nxt.rd_data = {23'h000000,
                                     (s_r.speed >= `SPEED_SHOWN_MIN) &&
                                     (s_r.speed <= `SPEED_SHOWN_MAX), s_r.speed};
        `REG_CTRL: s_nxt.rd_data = {30'h00000000, s_r.ctrl};
        default: s_nxt.rd_data = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s_r          <= '0;
      s_r.int_mask <= `INT_MASK_RESET;
      s_r.ctrl     <= `CTRL_RESET;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA  = s_r.rd_data;
  assign MOTOR_FWD  = s_r.motor_fwd;
  assign MOTOR_REV  = s_r.motor_rev;
  assign MOTOR_FAST = s_r.motor_fast;
  assign HALT_LAMP  = s_r.halt_lamp;
  assign FAULT_LAMP = s_r.fault_lamp;
  assign INDICATOR  = s_r.ind;
  assign IRQ        = s_r.irq;

endmodule

// ==== verilog/tape_diag_map.svh ====
`ifndef TAPE_DIAG_MAP_SVH
`define TAPE_DIAG_MAP_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_FREQ_MHZ      100
`define FLUX_PER_INCH     1600
// Gate time that makes the flux count equal to speed in 0.1 ips
`define SPEED_WIN_US      (10000000 / `FLUX_PER_INCH)
`define BUZZ_ON_MS        150
`define BUZZ_OFF_MS       150
`define DBL_PRESS_MS      500
`define TICKS_PER_INCH    1
`define MOVE_INCHES       8
`define SETTLE_INCHES     4
`define MID_TAPE_INCHES   1800

// ----------------------------------------------------------------
// Routine addresses and display codes
// ----------------------------------------------------------------
`define ADDR_FWD_FAST     12'h2C8
`define ADDR_REV_FAST     12'h2CC
`define ADDR_SPEED        12'h34E
`define ADDR_MEAS_FWD     12'h35A
`define ADDR_MEAS_REV     12'h38A
`define ADDR_MEAS_END     12'h3FC
`define CODE_RUN_END      12'h2F4
`define CODE_SERVO        12'h2ED
`define CODE_NO_HOLE      12'h2F7

// ----------------------------------------------------------------
// Speed code limits
// ----------------------------------------------------------------
`define SPEED_SHOWN_MIN   8'hD9
`define SPEED_TOL_LO      8'hE0
`define SPEED_TOL_HI      8'hEC
`define SPEED_SHOWN_MAX   8'hF3
`define SPEED_SAT         8'hFF
`define BUZZ_SLOW         2'h1
`define BUZZ_FAST         2'h2
`define BUZZ_TOL          2'h3

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
`define REG_STATUS        8'h00
`define REG_INT_STAT      8'h04
`define REG_INT_MASK      8'h08
`define REG_SPEED         8'h0C
`define REG_CTRL          8'h10
`define IRQ_DONE          0
`define IRQ_FAULT         1
`define IRQ_MEAS          2
`define IRQ_TOL           3
`define CTRL_ABORT        0
`define CTRL_STRICT       1
`define INT_MASK_RESET    4'h0
`define CTRL_RESET        2'h2

`endif

// ==== verilog/tape_diag_pkg.sv ====
package tape_diag_pkg;

  typedef enum logic [3:0] {
    S_IDLE,
    S_PREPOS,
    S_RUN,
    S_MIDSEEK,
    S_MIDHALT,
    S_MEAS,
    S_CORR,
    S_MEASHALT,
    S_PRESS2,
    S_HALT,
    S_FAULT
  } state_t;

  typedef struct packed {
    logic        start;
    logic        bot;
    logic        eot;
    logic        hole;
    logic        servo;
    logic        tick;
    logic        flux;
    logic        main_view;
    logic [11:0] addr;
  } sensors_t;

  typedef struct packed {
    state_t      st;
    logic [11:0] routine;
    logic [11:0] code;
    logic [7:0]  speed;
    logic [7:0]  flux_cnt;
    logic        dir_fwd;
    logic        meas_fwd;
    logic        fwd_ok;
    logic        hole_seen;
    logic        win_on;
    logic        win_done;
    logic [15:0] ticks;
    logic [25:0] timer;
    logic        start_q;
    logic        tick_q;
    logic        hole_q;
    logic        flux_q;
    logic        motor_fwd;
    logic        motor_rev;
    logic        motor_fast;
    logic        halt_lamp;
    logic        fault_lamp;
    logic [11:0] ind;
    logic        irq;
    logic [31:0] rd_data;
    logic [3:0]  int_stat;
    logic [3:0]  int_mask;
    logic [1:0]  ctrl;
    logic        buzz_go;
    logic [1:0]  buzz_n;
  } diag_state_t;

endpackage

// ==== verilog/pin_sync.sv ====
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  // Stage one feeds stage two only; a bit moves once two and three agree
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q  = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.q & (s_r.s2 ^ s_r.s3));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule

// ==== verilog/buzz_pulser.sv ====
module buzz_pulser #(
  parameter int ON_CYC  = 15000000,
  parameter int OFF_CYC = 15000000
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       go,
  input  wire logic [1:0] count,
  output logic            buzz
);

  typedef struct packed {
    logic [1:0]  left;
    logic [25:0] t;
    logic        buzz;
  } buzz_t;

  buzz_t s_r;
  buzz_t s_nxt;

  // A new request restarts the burst; the last pulse needs no gap after it
  always_comb begin
    s_nxt = s_r;
    if (go) begin
      s_nxt.left = count;
      s_nxt.buzz = (count != 2'h0);
      s_nxt.t    = 26'(ON_CYC - 1);
    end else if (s_r.left != 2'h0) begin
      if (s_r.t != 26'h0) begin
        s_nxt.t = s_r.t - 26'h1;
      end else if (s_r.buzz) begin
        s_nxt.buzz = 1'b0;
        s_nxt.left = s_r.left - 2'h1;
        s_nxt.t    = 26'(OFF_CYC - 1);
      end else begin
        s_nxt.buzz = 1'b1;
        s_nxt.t    = 26'(ON_CYC - 1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign buzz = s_r.buzz;

endmodule

// ==== testbench/tape_diag_monitor.sv ====
`include "tape_diag_map.svh"

module tape_diag_monitor (
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  input wire logic        START_BTN,
  input wire logic        DISPLAY_MAIN_SEL,
  input wire logic        SERVO_UNSAFE,
  input wire logic        MOTOR_FWD,
  input wire logic        MOTOR_REV,
  input wire logic        HALT_LAMP,
  input wire logic        FAULT_LAMP,
  input wire logic [11:0] INDICATOR
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Transport and panel properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic moving;
  assign moving = MOTOR_FWD || MOTOR_REV;

  a_motor_one_way: assert property (!(MOTOR_FWD && MOTOR_REV))
    else $error("both motor directions driven");
  a_halt_stopped: assert property (HALT_LAMP |-> !moving)
    else $error("motor running with halt lamp lit");
  a_fault_both_lamps: assert property (FAULT_LAMP |-> HALT_LAMP && !moving)
    else $error("fault without halt lamp or with motor on");
  a_servo_stops_run: assert property (
    $rose(SERVO_UNSAFE) && moving |-> ##[1:10] (FAULT_LAMP && !moving))
    else $error("servo unsafe did not stop transport");
  a_fault_code_shown: assert property (
    $rose(FAULT_LAMP) && !DISPLAY_MAIN_SEL |-> INDICATOR inside {`CODE_SERVO, `CODE_NO_HOLE})
    else $error("fault without fault code");
  a_end_code_shown: assert property (
    $rose(HALT_LAMP) && !FAULT_LAMP && !DISPLAY_MAIN_SEL
      |-> INDICATOR inside {`CODE_RUN_END, `ADDR_MEAS_FWD, `ADDR_MEAS_END})
    else $error("halt without end code");
  a_main_view_dark: assert property (
    DISPLAY_MAIN_SEL [*8] |-> INDICATOR[11:8] == 4'h0)
    else $error("upper indicators lit in main view");
  a_fault_holds: assert property (
    (!START_BTN) [*8] ##0 FAULT_LAMP |=> FAULT_LAMP && HALT_LAMP)
    else $error("fault state left without start");
endmodule

bind tape_transport_diag_sequencer tape_diag_monitor u_mon (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .START_BTN(START_BTN),
  .DISPLAY_MAIN_SEL(DISPLAY_MAIN_SEL), .SERVO_UNSAFE(SERVO_UNSAFE),
  .MOTOR_FWD(MOTOR_FWD), .MOTOR_REV(MOTOR_REV), .HALT_LAMP(HALT_LAMP),
  .FAULT_LAMP(FAULT_LAMP), .INDICATOR(INDICATOR));

// ==== testbench/tape_transport_model.sv ====
module tape_transport_model #(
  parameter int LEN       = 60,
  parameter int INIT_POS  = 30,
  parameter int FAST_HALF = 10,
  parameter int SLOW_HALF = 260
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       fwd,
  input  wire logic       rev,
  input  wire logic       fast,
  input  wire logic       no_hole,
  input  wire logic [1:0] flux_mode,
  output logic            bot,
  output logic            eot,
  output logic            hole,
  output logic            tick,
  output logic            flux,
  output int              pos
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Reel position, tach and reference track
  // ----------------------------------------
  int   tcnt;
  int   fcnt;
  logic alt;
  // Flux period 9, 8.5 or 8 cycles: slow, in tolerance, fast
  int   per;
  assign per = 8 + ((flux_mode == 2'h0) ? 1 : (flux_mode == 2'h1) ? int'(alt) : 0);
  assign bot = (pos == 0);
  assign eot = (pos == LEN);
  assign hole = !no_hole && (pos == 3 || pos == LEN - 3);
  assign flux = (fwd || rev) && fcnt < 4;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= INIT_POS;
      tcnt <= 0;
      tick <= 1'b0;
      fcnt <= 0;
      alt <= 1'b0;
    end else if (fwd || rev) begin
      tcnt <= tcnt + 1;
      fcnt <= (fcnt >= per - 1) ? 0 : fcnt + 1;
      if (fcnt >= per - 1) alt <= !alt;
      if (tcnt >= (fast ? FAST_HALF : SLOW_HALF) - 1) begin
        tcnt <= 0;
        tick <= !tick;
        if (!tick && fwd && pos < LEN) pos <= pos + 1;
        if (!tick && rev && pos > 0) pos <= pos - 1;
      end
    end
  end
endmodule

// ==== testbench/tb_tape_transport_diag_sequencer.sv ====
`include "tape_diag_map.svh"

module tb_tape_transport_diag_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_SYS, RST_B, START_BTN, DISPLAY_MAIN_SEL, SERVO_UNSAFE, REG_WR, REG_RD;
  logic [11:0] ADDR_SW, INDICATOR;
  logic [7:0]  REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, d;
  logic        MOTOR_FWD, MOTOR_REV, MOTOR_FAST, HALT_LAMP, FAULT_LAMP, BUZZER, IRQ;
  logic        bot, eot, hole, tick, flux, no_hole, buzz_q, ce;
  logic [1:0]  flux_mode;
  int          pos, p0, nbuzz, fails, compares, k;
  int          modes[3] = '{0, 2, 1};
  int          buzzes[3] = '{1, 2, 3};
  logic [7:0]  lo[3] = '{`SPEED_SHOWN_MIN, 8'hED, `SPEED_TOL_LO};
  logic [7:0]  hi[3] = '{8'hDF, `SPEED_SAT, `SPEED_TOL_HI};

  tape_transport_diag_sequencer #(.WIN_CYC(1960), .DBL_CYC(100), .BUZZ_ON_CYC(10),
    .BUZZ_OFF_CYC(10), .MID_TICKS(20)) dut (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(ce), .START_BTN(START_BTN), .ADDR_SW(ADDR_SW),
    .DISPLAY_MAIN_SEL(DISPLAY_MAIN_SEL), .LEADER_BOT(bot), .LEADER_EOT(eot),
    .NEAR_END_OF_TAPE_HOLE(hole), .SERVO_UNSAFE(SERVO_UNSAFE), .TAPE_TICK(tick),
    .READ_FLUX(flux), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MOTOR_FWD(MOTOR_FWD), .MOTOR_REV(MOTOR_REV),
    .MOTOR_FAST(MOTOR_FAST), .HALT_LAMP(HALT_LAMP), .FAULT_LAMP(FAULT_LAMP),
    .INDICATOR(INDICATOR), .BUZZER(BUZZER), .IRQ(IRQ));
  tape_transport_model u_tape (.clk(CLK_SYS), .rst_b(RST_B), .fwd(MOTOR_FWD),
    .rev(MOTOR_REV), .fast(MOTOR_FAST), .no_hole(no_hole), .flux_mode(flux_mode),
    .bot(bot), .eot(eot), .hole(hole), .tick(tick), .flux(flux), .pos(pos));

  // ----------------------------------------
  // Clock, buzz counter and helpers
  // ----------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    buzz_q <= BUZZER;
    if (BUZZER === 1'b1 && buzz_q === 1'b0) nbuzz++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] a);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
    @(posedge CLK_SYS);
  endtask
  // Release is what counts, so both levels outlast the pin filter
  task automatic press(input logic [11:0] a);
    ADDR_SW <= a;
    START_BTN <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    START_BTN <= 1'b0;
    repeat (12) @(posedge CLK_SYS);
  endtask
  task automatic wait_halt();
    for (int n = 0; n < 30000 && HALT_LAMP !== 1'b1; n++) @(posedge CLK_SYS);
    repeat (2) @(posedge CLK_SYS);
  endtask
  task automatic ends(input logic [11:0] code, input logic flt);
    wait_halt();
    chk("halt", HALT_LAMP, 1'b1);
    chk("fault", FAULT_LAMP, flt);
    chk("motor", {MOTOR_FWD, MOTOR_REV}, 2'b00);
    chk("code", INDICATOR, code);
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge CLK_SYS);
    fails++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {RST_B, START_BTN, DISPLAY_MAIN_SEL, SERVO_UNSAFE, REG_WR, REG_RD, no_hole} = '0;
    {ADDR_SW, REG_ADDR, REG_WDATA, flux_mode} = '0;
    ce = 1'b1;
    fails = 0;
    compares = 0;
    nbuzz = 0;
    repeat (20) @(posedge CLK_SYS);
    chk("reset outs", {MOTOR_FWD, MOTOR_REV, HALT_LAMP, FAULT_LAMP, IRQ, INDICATOR}, 0);
    RST_B <= 1'b1;
    @(posedge CLK_SYS);
    rd(`REG_INT_MASK);
    chk("mask reset", d, `INT_MASK_RESET);
    rd(`REG_CTRL);
    chk("ctrl reset", d, `CTRL_RESET);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14);
    chk("unmapped", d, 0);
    wr(`REG_INT_MASK, 32'h1);
    press(`ADDR_FWD_FAST);
    ends(`CODE_RUN_END, 1'b0);
    chk("fwd leader", pos, 60);
    chk("irq on", IRQ, 1'b1);
    wr(`REG_INT_STAT, 32'h1);
    @(posedge CLK_SYS);
    chk("irq cleared", IRQ, 1'b0);
    press(`ADDR_REV_FAST);
    ends(`CODE_RUN_END, 1'b0);
    chk("rev leader", pos, 0);
    wr(`REG_INT_MASK, 32'h0);
    rd(`REG_INT_STAT);
    chk("stat sticky", d, 32'h1);
    chk("irq masked", IRQ, 1'b0);
    no_hole <= 1'b1;
    press(`ADDR_FWD_FAST);
    ends(`CODE_NO_HOLE, 1'b1);
    no_hole <= 1'b0;
    press(`ADDR_REV_FAST);
    for (int n = 0; n < 3000 && pos > 50; n++) @(posedge CLK_SYS);
    SERVO_UNSAFE <= 1'b1;
    ends(`CODE_SERVO, 1'b1);
    SERVO_UNSAFE <= 1'b0;
    press(12'h123);
    chk("other addr", {HALT_LAMP, FAULT_LAMP, INDICATOR}, 14'h0123);
    // A press while frozen must leave no trace once enabled again
    ce <= 1'b0;
    press(`ADDR_FWD_FAST);
    ce <= 1'b1;
    repeat (20) @(posedge CLK_SYS);
    chk("ce freeze", {MOTOR_FWD, MOTOR_REV, INDICATOR}, 14'h0123);
    press(`ADDR_SPEED);
    ends(`ADDR_MEAS_FWD, 1'b0);
    chk("mid tape", pos, 20);
    DISPLAY_MAIN_SEL <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      // Reverse pass runs in tolerance so its travel is not undone
      k = (i == 3) ? 2 : i;
      p0 = pos;
      nbuzz = 0;
      flux_mode <= 2'(modes[k]);
      press(`ADDR_SPEED);
      if (i == 3) press(`ADDR_SPEED);
      repeat (120) @(posedge CLK_SYS);
      wait_halt();
      repeat (100) @(posedge CLK_SYS);
      chk("buzz", nbuzz, buzzes[k]);
      chk("upper dark", INDICATOR[11:8], 4'h0);
      chk("code lo", INDICATOR[7:0] >= lo[k], 1'b1);
      chk("code hi", INDICATOR[7:0] <= hi[k], 1'b1);
      chk("move", pos - p0, (i == 2) ? 8 : (i == 3) ? -8 : 0);
    end
    print_verdict();
  end
endmodule
